/* hw/bopx_alu.sv */
// combinational result and carry for one byte instruction
`timescale 1ns/1ps

module bopx_alu (
  input wire bopx_pkg::bopx_op_e op,
  input wire logic [7:0] w_val,
  input wire logic [7:0] f_val,
  output logic [7:0] res,
  output logic c_out,
  output logic c_we
);

  // ***************************************************
  // operation select
  // ***************************************************

  // result, carry and carry write per operation
  always_comb begin
    res = f_val;
    c_out = 1'b0;
    c_we = 1'b0;
    case (op)
      bopx_pkg::INCREMENT_FILE_OP: begin
        res = f_val + bopx_pkg::ONE_8;
      end
      bopx_pkg::OR_WORK_WITH_FILE_OP: begin
        res = w_val | f_val;
      end
      bopx_pkg::SHIFT_LEFT_LOGICAL_OP: begin
        res = {f_val[6:0], 1'b0};
        c_out = f_val[7];
        c_we = 1'b1;
      end
      bopx_pkg::SHIFT_RIGHT_LOGICAL_OP: begin
        res = {1'b0, f_val[7:1]};
        c_out = f_val[0];
        c_we = 1'b1;
      end
      bopx_pkg::MOVE_FILE_OP: begin
        res = f_val;
      end
      bopx_pkg::INDIRECT_LOAD_OP: begin
        res = f_val;
      end
      default: begin
        res = f_val;
      end
    endcase
  end

endmodule // bopx_alu

/* hw/bopx_exec.sv */
// byte-op and indirect-load execution unit with an AXI4-Lite slave
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module bopx_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ***************************************************
  // state
  // ***************************************************

  logic aw_got_ff, w_got_ff, b_valid_ff, r_valid_ff, z_ff, c_ff;
  logic [1:0] b_resp_ff, r_resp_ff;
  logic [3:0] w_strb_ff;
  logic [6:0] fsel_ff;
  logic [7:0] aw_addr_ff, w_ff;
  logic [15:0] ptr0_ff, ptr1_ff;
  logic [31:0] w_data_ff, r_data_ff;
  logic [7:0] file_mem [bopx_pkg::FILE_DEPTH];

  logic wr_fire, exec, dsel, psel, rel, is_ind;
  logic c_out, c_we, z_new, wb_en, w_we;
  bopx_pkg::bopx_op_e op;
  logic [1:0] mode;
  logic [5:0] ofs;
  logic [6:0] faddr;
  logic [7:0] opnd, res;
  logic [15:0] sel_ptr, ofs_ext, eff, nxt_ptr;
  logic [31:0] wr_word;

  // ***************************************************
  // helpers
  // ***************************************************

  // true for the two file addresses without storage
  function automatic logic is_port(input logic [6:0] f);
    return (f == bopx_pkg::PORT0_ADDR) || (f == bopx_pkg::PORT1_ADDR);
  endfunction

  // maps a file address to its memory address
  function automatic logic [15:0] resolve(input logic [6:0] f);
    if (f == bopx_pkg::PORT1_ADDR) return ptr1_ff;
    if (f == bopx_pkg::PORT0_ADDR) return ptr0_ff;
    return 16'(f);
  endfunction

  // true when an address lands on real file storage
  function automatic logic has_store(input logic [15:0] a);
    return (a[15:7] == bopx_pkg::HIGH_ZERO) && !is_port(a[6:0]);
  endfunction

  // reads memory; unbacked addresses read zero
  function automatic logic [7:0] mem_rd(input logic [15:0] a);
    if (has_store(a)) return file_mem[a[6:0]];
    return bopx_pkg::ZERO_8;
  endfunction

  // true for decoded register addresses
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      bopx_pkg::REG_CMD, bopx_pkg::REG_WREG, bopx_pkg::REG_STATUS,
      bopx_pkg::REG_PTR0, bopx_pkg::REG_PTR1, bopx_pkg::REG_FSEL,
      bopx_pkg::REG_FDATA: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // register contents as seen by software
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = bopx_pkg::ZERO_32;
    case (a)
      bopx_pkg::REG_WREG: v = 32'(w_ff);
      bopx_pkg::REG_STATUS: begin
        v[bopx_pkg::STAT_Z_BIT] = z_ff;
        v[bopx_pkg::STAT_C_BIT] = c_ff;
      end
      bopx_pkg::REG_PTR0: v = 32'(ptr0_ff);
      bopx_pkg::REG_PTR1: v = 32'(ptr1_ff);
      bopx_pkg::REG_FSEL: v = 32'(fsel_ff);
      bopx_pkg::REG_FDATA: v = 32'(mem_rd(resolve(fsel_ff)));
      default: v = bopx_pkg::ZERO_32;
    endcase
    return v;
  endfunction

  // ***************************************************
  // axi4-lite write channels
  // ***************************************************

  assign s_axi_awready = !aw_got_ff && !b_valid_ff;
  assign s_axi_wready = !w_got_ff && !b_valid_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !b_valid_ff;
  assign s_axi_bvalid = b_valid_ff;
  assign s_axi_bresp = b_resp_ff;

  // write address holding
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= bopx_pkg::ZERO_8;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge clock) begin
    if (rst) begin
      w_got_ff <= 1'b0;
      w_data_ff <= bopx_pkg::ZERO_32;
      w_strb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_ff <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge clock) begin
    if (rst) begin
      b_valid_ff <= 1'b0;
      b_resp_ff <= bopx_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      b_valid_ff <= 1'b1;
      b_resp_ff <= is_mapped(aw_addr_ff) ? bopx_pkg::RESP_OKAY
                                         : bopx_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      b_valid_ff <= 1'b0;
    end
  end

  // byte-lane merge of new data over current contents
  always_comb begin
    wr_word = rd_word(aw_addr_ff);
    for (int i = 0; i < 4; i++) begin
      if (w_strb_ff[i]) begin
        wr_word[i*8 +: 8] = w_data_ff[i*8 +: 8];
      end
    end
  end

  // ***************************************************
  // axi4-lite read channels
  // ***************************************************

  assign s_axi_arready = !r_valid_ff;
  assign s_axi_rvalid = r_valid_ff;
  assign s_axi_rdata = r_data_ff;
  assign s_axi_rresp = r_resp_ff;

  // read data capture
  always_ff @(posedge clock) begin
    if (rst) begin
      r_valid_ff <= 1'b0;
      r_data_ff <= bopx_pkg::ZERO_32;
      r_resp_ff <= bopx_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      r_valid_ff <= 1'b1;
      r_data_ff <= rd_word(s_axi_araddr);
      r_resp_ff <= is_mapped(s_axi_araddr) ? bopx_pkg::RESP_OKAY
                                           : bopx_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      r_valid_ff <= 1'b0;
    end
  end

  // ***************************************************
  // instruction decode and addressing
  // ***************************************************

  // a command write executes on the response edge
  assign exec = wr_fire && (aw_addr_ff == bopx_pkg::REG_CMD);
  assign op = bopx_pkg::bopx_op_e'(
    w_data_ff[bopx_pkg::CMD_OP_LSB +: bopx_pkg::CMD_OP_W]);
  assign dsel = w_data_ff[bopx_pkg::CMD_D_BIT];
  assign faddr = w_data_ff[bopx_pkg::CMD_F_LSB +: bopx_pkg::FADDR_W];
  assign psel = w_data_ff[bopx_pkg::CMD_PSEL_BIT];
  assign mode = w_data_ff[bopx_pkg::CMD_MODE_LSB +: 2];
  assign rel = w_data_ff[bopx_pkg::CMD_REL_BIT];
  assign ofs = w_data_ff[bopx_pkg::CMD_OFS_LSB +: bopx_pkg::OFS_W];
  assign is_ind = (op == bopx_pkg::INDIRECT_LOAD_OP);
  assign sel_ptr = psel ? ptr1_ff : ptr0_ff;
  assign ofs_ext = {{(bopx_pkg::PTR_W - bopx_pkg::OFS_W){ofs[5]}}, ofs};

  // effective address and next pointer, 16-bit wrap
  always_comb begin
    nxt_ptr = sel_ptr;
    eff = resolve(faddr);
    if (is_ind && rel) begin
      eff = sel_ptr + ofs_ext;
    end else if (is_ind) begin
      case (mode)
        bopx_pkg::MODE_PRE_INC, bopx_pkg::MODE_POST_INC: begin
          nxt_ptr = sel_ptr + bopx_pkg::ONE_16;
        end
        default: begin
          // both decrement modes
          nxt_ptr = sel_ptr - bopx_pkg::ONE_16;
        end
      endcase
      // pre modes address the stepped pointer, post modes the old one
      eff = (mode == bopx_pkg::MODE_POST_INC ||
             mode == bopx_pkg::MODE_POST_DEC) ? sel_ptr : nxt_ptr;
    end
  end

  // operand follows memory contents as well as the address
  always_comb opnd = mem_rd(eff);

  bopx_alu u_alu (
    .op(op),
    .w_val(w_ff),
    .f_val(opnd),
    .res(res),
    .c_out(c_out),
    .c_we(c_we)
  );

  // destination and zero decisions
  assign z_new = (res == bopx_pkg::ZERO_8);
  assign w_we = exec && (is_ind || !dsel);
  assign wb_en = exec && !is_ind && dsel && has_store(eff);

  // ***************************************************
  // architectural registers
  // ***************************************************

  // working register
  always_ff @(posedge clock) begin
    if (rst) begin
      w_ff <= bopx_pkg::ZERO_8;
    end else if (w_we) begin
      w_ff <= res;
    end else if (wr_fire && aw_addr_ff == bopx_pkg::REG_WREG) begin
      w_ff <= wr_word[7:0];
    end
  end

  // zero and carry flags
  always_ff @(posedge clock) begin
    if (rst) begin
      z_ff <= 1'b0;
      c_ff <= 1'b0;
    end else if (exec) begin
      z_ff <= z_new;
      if (c_we) begin
        c_ff <= c_out;
      end
    end else if (wr_fire && aw_addr_ff == bopx_pkg::REG_STATUS) begin
      z_ff <= wr_word[bopx_pkg::STAT_Z_BIT];
      c_ff <= wr_word[bopx_pkg::STAT_C_BIT];
    end
  end

  // pointers: instruction update, else software write
  always_ff @(posedge clock) begin
    if (rst) begin
      ptr0_ff <= bopx_pkg::ZERO_16;
      ptr1_ff <= bopx_pkg::ZERO_16;
    end else if (exec && is_ind) begin
      if (psel) begin
        ptr1_ff <= nxt_ptr;
      end else begin
        ptr0_ff <= nxt_ptr;
      end
    end else if (wr_fire && aw_addr_ff == bopx_pkg::REG_PTR0) begin
      ptr0_ff <= wr_word[15:0];
    end else if (wr_fire && aw_addr_ff == bopx_pkg::REG_PTR1) begin
      ptr1_ff <= wr_word[15:0];
    end
  end

  // software file window select
  always_ff @(posedge clock) begin
    if (rst) begin
      fsel_ff <= 7'h00;
    end else if (wr_fire && aw_addr_ff == bopx_pkg::REG_FSEL) begin
      fsel_ff <= wr_word[6:0];
    end
  end

  // file memory: write-back or software window write
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < bopx_pkg::FILE_DEPTH; i++) begin
        file_mem[i] <= bopx_pkg::ZERO_8;
      end
    end else if (wb_en) begin
      file_mem[eff[6:0]] <= res;
    end else if (wr_fire && aw_addr_ff == bopx_pkg::REG_FDATA &&
                 has_store(resolve(fsel_ff))) begin
      file_mem[7'(resolve(fsel_ff))] <= wr_word[7:0];
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_DEST_W: assert property (
    exec && !is_ind && !dsel |-> !wb_en ##1 w_ff == $past(res))
    else $error("d=0 result not in W");
  AST_DEST_F: assert property (
    wb_en |=> file_mem[$past(eff[6:0])] == $past(res) &&
      w_ff == $past(w_ff))
    else $error("d=1 result not in file");
  AST_INC: assert property (
    exec && op == bopx_pkg::INCREMENT_FILE_OP
    |-> res == opnd + bopx_pkg::ONE_8 ##1 c_ff == $past(c_ff))
    else $error("increment wrong or carry touched");
  AST_IOR: assert property (
    exec && op == bopx_pkg::OR_WORK_WITH_FILE_OP
    |-> res == (w_ff | opnd) ##1 c_ff == $past(c_ff))
    else $error("or wrong or carry touched");
  AST_LSL: assert property (
    exec && op == bopx_pkg::SHIFT_LEFT_LOGICAL_OP
    |-> res == {opnd[6:0], 1'b0} ##1 c_ff == $past(opnd[7]))
    else $error("left shift wrong");
  AST_LSR: assert property (
    exec && op == bopx_pkg::SHIFT_RIGHT_LOGICAL_OP
    |-> res == {1'b0, opnd[7:1]} ##1 c_ff == $past(opnd[0]))
    else $error("right shift wrong");
  AST_MOV: assert property (
    exec && op == bopx_pkg::MOVE_FILE_OP && !dsel
    |=> w_ff == $past(opnd) && z_ff == ($past(opnd) == bopx_pkg::ZERO_8))
    else $error("move file wrong");
  AST_IND: assert property (
    exec && is_ind |=> w_ff == $past(opnd))
    else $error("indirect load wrong");
  AST_MODE: assert property (
    exec && is_ind |-> eff == (rel ? sel_ptr + ofs_ext :
      mode[1] ? sel_ptr : mode[0] ? sel_ptr - bopx_pkg::ONE_16
                                  : sel_ptr + bopx_pkg::ONE_16))
    else $error("effective address wrong");
  AST_PTR: assert property (
    exec && is_ind && !psel |=> ptr0_ff == ($past(rel) ? $past(ptr0_ff) :
      $past(mode[0]) ? $past(ptr0_ff) - bopx_pkg::ONE_16
                     : $past(ptr0_ff) + bopx_pkg::ONE_16))
    else $error("pointer update wrong");
  AST_FLAGS: assert property (
    exec && is_ind |=> c_ff == $past(c_ff) &&
      z_ff == ($past(res) == bopx_pkg::ZERO_8))
    else $error("indirect flags wrong");

endmodule // bopx_exec

/* hw/bopx_pkg.sv */
// constants shared by the byte-op and indirect-move datapath
package bopx_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W = 16;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned OFS_W = 6;

  // register byte addresses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WREG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PTR0 = 8'h0C;
  localparam logic [7:0] REG_PTR1 = 8'h10;
  localparam logic [7:0] REG_FSEL = 8'h14;
  localparam logic [7:0] REG_FDATA = 8'h18;

  // command word fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_OP_W = 3;
  localparam int unsigned CMD_D_BIT = 3;
  localparam int unsigned CMD_F_LSB = 4;
  localparam int unsigned CMD_PSEL_BIT = 11;
  localparam int unsigned CMD_MODE_LSB = 12;
  localparam int unsigned CMD_REL_BIT = 14;
  localparam int unsigned CMD_OFS_LSB = 15;

  // status bits
  localparam int unsigned STAT_Z_BIT = 0;
  localparam int unsigned STAT_C_BIT = 1;

  typedef enum logic [2:0] {
    INCREMENT_FILE_OP = 3'h0,
    OR_WORK_WITH_FILE_OP = 3'h1,
    SHIFT_LEFT_LOGICAL_OP = 3'h2,
    SHIFT_RIGHT_LOGICAL_OP = 3'h3,
    MOVE_FILE_OP = 3'h4,
    INDIRECT_LOAD_OP = 3'h5
  } bopx_op_e;

  // indirect_mode_field encodings
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // file addresses of the two indirect data ports
  localparam logic [6:0] PORT0_ADDR = 7'h00;
  localparam logic [6:0] PORT1_ADDR = 7'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0] ZERO_8 = 8'h00;
  localparam logic [7:0] ONE_8 = 8'h01;
  localparam logic [15:0] ZERO_16 = 16'h0000;
  localparam logic [15:0] ONE_16 = 16'h0001;
  localparam logic [31:0] ZERO_32 = 32'h0000_0000;
  localparam logic [8:0] HIGH_ZERO = 9'h000;

endpackage

/* verification/test_byte_op_and_indirect_move_exec.sv */
// self-checking bench for the byte-op and indirect-load unit
`timescale 1ns/1ps

module test_byte_op_and_indirect_move_exec;
  // ****************************************
  // stimulus signals and bookkeeping
  // ****************************************
  typedef struct packed {
    bopx_pkg::bopx_op_e op;
    logic d;
    logic [7:0] w;
    logic [7:0] fv;
    logic [7:0] st;
    logic [7:0] ew;
    logic [7:0] ef;
    logic [7:0] est;
  } bopx_row_s;
  logic clock, rst;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int errors, comparisons, lat;
  bopx_row_s rows[10];
  logic [7:0] mv[4];
  logic [15:0] mp[4];
  logic [1:0] resp;
  logic [31:0] data;

  bopx_exec DUT (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    #(8 * 20000);
    errors = errors + 1;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end

  // ****************************************
  // compare, bus and verdict tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR %0t response %h expected %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, ra, rw, ok;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clock);
      ra = awready;
      rw = wready;
      @(posedge clock);
      if (ra && !ta) begin
        awvalid <= 1'b0;
        ta = 1'b1;
      end
      if (rw && !tw) begin
        wvalid <= 1'b0;
        tw = 1'b1;
      end
    end
    bready <= 1'b1;
    lat = 0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clock);
      ok = bvalid;
      resp = bresp;
      @(posedge clock);
      if (!ok) begin
        lat = lat + 1;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok) begin
      @(negedge clock);
      ok = arready;
      @(posedge clock);
    end
    arvalid <= 1'b0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clock);
      ok = rvalid;
      data = rdata;
      resp = rresp;
      @(posedge clock);
    end
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(data, exp);
    chk_resp(resp, bopx_pkg::RESP_OKAY);
  endtask

  task automatic set_file(input logic [6:0] f, input logic [7:0] v);
    wr(bopx_pkg::REG_FSEL, {25'h0000000, f});
    wr(bopx_pkg::REG_FDATA, {24'h000000, v});
  endtask

  function automatic logic [31:0] cmd_word(input logic [2:0] op,
    input logic d, input logic [6:0] f, input logic ps,
    input logic [1:0] md, input logic rel, input logic [5:0] ofs);
    logic [31:0] c;
    c = 32'h00000000;
    c[2:0] = op;
    c[3] = d;
    c[10:4] = f;
    c[11] = ps;
    c[13:12] = md;
    c[14] = rel;
    c[20:15] = ofs;
    return c;
  endfunction

  task automatic ind(input logic ps, input logic [1:0] md,
    input logic rel, input logic [5:0] ofs);
    wr(bopx_pkg::REG_CMD, cmd_word(3'h5, 1'b0, 7'h00, ps, md, rel, ofs));
  endtask

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    errors = 0;
    comparisons = 0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    rows = '{
      '{bopx_pkg::INCREMENT_FILE_OP, 0, 8'h12, 8'hFF, 2, 8'h00, 8'hFF, 3},
      '{bopx_pkg::INCREMENT_FILE_OP, 1, 8'h12, 8'h41, 2, 8'h12, 8'h42, 2},
      '{bopx_pkg::OR_WORK_WITH_FILE_OP, 0, 8'h0F, 8'hA0, 1, 8'hAF, 8'hA0, 0},
      '{bopx_pkg::OR_WORK_WITH_FILE_OP, 1, 8'h00, 8'h00, 0, 8'h00, 8'h00, 1},
      '{bopx_pkg::SHIFT_LEFT_LOGICAL_OP, 0, 8'h00, 8'h81, 0, 8'h02, 8'h81, 2},
      '{bopx_pkg::SHIFT_LEFT_LOGICAL_OP, 1, 8'h33, 8'h80, 0, 8'h33, 8'h00, 3},
      '{bopx_pkg::SHIFT_RIGHT_LOGICAL_OP, 0, 8'h33, 8'h01, 0, 8'h00, 8'h01, 3},
      '{bopx_pkg::SHIFT_RIGHT_LOGICAL_OP, 1, 8'h33, 8'hFE, 2, 8'h33, 8'h7F, 0},
      '{bopx_pkg::MOVE_FILE_OP, 0, 8'h33, 8'h00, 0, 8'h00, 8'h00, 1},
      '{bopx_pkg::MOVE_FILE_OP, 1, 8'h33, 8'h5A, 3, 8'h33, 8'h5A, 2}};
    mv = '{8'hA3, 8'hA1, 8'hA2, 8'hA2};
    mp = '{16'h0021, 16'h001F, 16'h0021, 16'h001F};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // reset values
    rd_chk(bopx_pkg::REG_WREG, 32'h00000000);
    rd_chk(bopx_pkg::REG_STATUS, 32'h00000000);
    rd_chk(bopx_pkg::REG_PTR0, 32'h00000000);
    rd_chk(bopx_pkg::REG_PTR1, 32'h00000000);
    $display("test reset done");
    // byte operations from the table
    foreach (rows[i]) begin
      set_file(7'h10, rows[i].fv);
      wr(bopx_pkg::REG_WREG, {24'h000000, rows[i].w});
      wr(bopx_pkg::REG_STATUS, {24'h000000, rows[i].st});
      wr(bopx_pkg::REG_CMD, cmd_word(rows[i].op, rows[i].d, 7'h10,
        1'b0, 2'h0, 1'b0, 6'h00));
      if (rows[i].op == bopx_pkg::MOVE_FILE_OP) begin
        chk(lat, 32'h00000001);
      end
      rd_chk(bopx_pkg::REG_WREG, {24'h0, rows[i].ew});
      rd_chk(bopx_pkg::REG_FDATA, {24'h0, rows[i].ef});
      rd_chk(bopx_pkg::REG_STATUS, {24'h0, rows[i].est});
    end
    $display("test table done");
    // all four pointer modes, odd modes on the second pointer
    set_file(7'h1F, 8'hA1);
    set_file(7'h20, 8'hA2);
    set_file(7'h21, 8'hA3);
    for (int m = 0; m < 4; m++) begin
      wr(bopx_pkg::REG_STATUS, 32'h00000002);
      wr(m[0] ? bopx_pkg::REG_PTR1 : bopx_pkg::REG_PTR0, 32'h00000020);
      ind(m[0], m[1:0], 1'b0, 6'h00);
      rd_chk(bopx_pkg::REG_WREG, {24'h0, mv[m]});
      rd_chk(bopx_pkg::REG_STATUS, 32'h00000002);
      rd_chk(m[0] ? bopx_pkg::REG_PTR1 : bopx_pkg::REG_PTR0,
        {16'h0, mp[m]});
    end
    $display("test modes done");
    // relative offsets at both ends of the range
    wr(bopx_pkg::REG_PTR1, 32'h00000040);
    ind(1'b1, 2'h0, 1'b1, 6'h20);
    rd_chk(bopx_pkg::REG_WREG, 32'h000000A2);
    ind(1'b1, 2'h3, 1'b1, 6'h1F);
    rd_chk(bopx_pkg::REG_WREG, 32'h00000000);
    rd_chk(bopx_pkg::REG_STATUS, 32'h00000003);
    rd_chk(bopx_pkg::REG_PTR1, 32'h00000040);
    $display("test relative done");
    // pointer wraps at both ends
    wr(bopx_pkg::REG_PTR0, 32'h0000FFFF);
    ind(1'b0, bopx_pkg::MODE_POST_INC, 1'b0, 6'h00);
    rd_chk(bopx_pkg::REG_PTR0, 32'h00000000);
    ind(1'b0, bopx_pkg::MODE_PRE_DEC, 1'b0, 6'h00);
    rd_chk(bopx_pkg::REG_PTR0, 32'h0000FFFF);
    $display("test wrap done");
    // indirect data ports redirect to the pointer target
    wr(bopx_pkg::REG_PTR0, 32'h00000030);
    set_file(bopx_pkg::PORT0_ADDR, 8'h77);
    rd_chk(bopx_pkg::REG_FDATA, 32'h00000077);
    wr(bopx_pkg::REG_FSEL, 32'h00000030);
    rd_chk(bopx_pkg::REG_FDATA, 32'h00000077);
    wr(bopx_pkg::REG_PTR1, 32'h00000031);
    set_file(7'h31, 8'h05);
    wr(bopx_pkg::REG_CMD, cmd_word(3'h0, 1'b1, bopx_pkg::PORT1_ADDR,
      1'b0, 2'h0, 1'b0, 6'h00));
    rd_chk(bopx_pkg::REG_FDATA, 32'h00000006);
    rd_chk(bopx_pkg::REG_PTR1, 32'h00000031);
    $display("test ports done");
    // unmapped address answers with an error
    wr(8'h1C, 32'h000000FF);
    chk_resp(resp, bopx_pkg::RESP_SLVERR);
    rd(8'h1C);
    chk_resp(resp, bopx_pkg::RESP_SLVERR);
    chk(data, 32'h00000000);
    $display("test unmapped done");
    // byte enables merge over current contents
    wr(bopx_pkg::REG_PTR0, 32'h00001234);
    wstrb <= 4'h1;
    wr(bopx_pkg::REG_PTR0, 32'h000000AB);
    wstrb <= 4'hF;
    rd_chk(bopx_pkg::REG_PTR0, 32'h000012AB);
    $display("test strobes done");
    // reset in mid-run clears state
    wr(bopx_pkg::REG_WREG, 32'h0000005A);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd_chk(bopx_pkg::REG_WREG, 32'h00000000);
    rd_chk(bopx_pkg::REG_STATUS, 32'h00000000);
    rd_chk(bopx_pkg::REG_PTR1, 32'h00000000);
    rd_chk(bopx_pkg::REG_FDATA, 32'h00000000);
    $display("test mid-run reset done");
    close_out();
  end
endmodule // test_byte_op_and_indirect_move_exec
